// ### logic/level_group_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "level_sel_cfg.svh"
module level_group_decode #(
	parameter int GROUPS = `LVL_GROUPS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstnInt,
	// Control word in, group selects out
	level_sel_if.decoder lvl
);
	import level_sel_pkg::*;

	// ==========================================================
	// Per-group select lines
	groupSel_type highSel_r, highSel_nxt;
	groupSel_type lowSel_r, lowSel_nxt;

	genvar g;
	generate
		for (g = 0; g < GROUPS; g++) begin : grp
			// Group 0 is channels 72-61, top group is 120-109
			always_comb begin
				highSel_nxt[g] = lvl.ctrlWord[`LVL_HI_LSB + g];
				lowSel_nxt[g] = lvl.ctrlWord[`LVL_LO_LSB + g];
			end
		end
	endgenerate

	// Registered so the drivers never see decode glitches
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			highSel_r <= `LVL_SEL_RESET;
			lowSel_r <= `LVL_SEL_RESET;
		end else begin
			highSel_r <= highSel_nxt;
			lowSel_r <= lowSel_nxt;
		end
	end

	assign lvl.highSel = highSel_r;
	assign lvl.lowSel = lowSel_r;
endmodule
`default_nettype wire

// ### logic/level_sel_cfg.svh
`ifndef LEVEL_SEL_CFG_SVH
`define LEVEL_SEL_CFG_SVH

// ==========================================================
// Register map
`define LVL_ADDR_W 12
`define LVL_CTRL_OFFSET 12'ha00
`define LVL_REV_OFFSET 12'ha02

// ==========================================================
// Field layout
`define LVL_GROUPS 5
`define LVL_HI_LSB 8
`define LVL_LO_LSB 0
`define LVL_LANE_W 8
`define LVL_LANE_LO 0
`define LVL_LANE_HI 1

// ==========================================================
// Reset and fixed values
`define LVL_CTRL_RESET 16'h0000
`define LVL_SEL_RESET 5'h00
`define LVL_WORD_ZERO 16'h0000
`define LVL_REV_UPPER 8'h00
`define LVL_REV_DEFAULT 8'h01

`endif

// ### logic/level_sel_if.sv
`timescale 1ns/1ps
`default_nettype none
interface level_sel_if;
	import level_sel_pkg::*;
	regWord_type ctrlWord;
	groupSel_type highSel;
	groupSel_type lowSel;
	modport owner (output ctrlWord, input highSel, input lowSel);
	modport decoder (input ctrlWord, output highSel, output lowSel);
endinterface
`default_nettype wire

// ### logic/level_sel_pkg.sv
`default_nettype none
package level_sel_pkg;
	typedef logic [15:0] regWord_type;
	typedef logic [11:0] regAddr_type;
	typedef logic [4:0] groupSel_type;
	typedef logic [1:0] laneEn_type;
	typedef enum logic [1:0] {HIT_NONE, HIT_CTRL, HIT_REV} regHit_type;
	typedef enum logic {ST_IDLE, ST_ANSWER} busState_type;
endpackage
`default_nettype wire

// ### logic/output_level_select_regs.sv
// Overview of operation
// - Bits 12..8 pick high level, 28/73 V
// - Bits 4..0 pick low level, ground/2.5 V
// - Bits 15..13 stored, read back, inert
// - Bits 7..5 stored, read back, inert
// - Revision upper byte always reads zero
// - Revision lower byte is fixed code
`timescale 1ns/1ps
`default_nettype none
`include "level_sel_cfg.svh"
module output_level_select_regs #(
	parameter logic [7:0] HW_REVISION = `LVL_REV_DEFAULT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Backplane register access
	input wire level_sel_pkg::regAddr_type busAddr,
	input wire logic busStrobeN,
	input wire logic busWriteN,
	input wire level_sel_pkg::laneEn_type busLaneN,
	input wire level_sel_pkg::regWord_type busWdata,
	output logic [15:0] busRdata,
	output logic busAckN,
	output logic busErrN,
	// Drive level selects, one bit per 12-channel group
	output logic [4:0] highDriveLevelSelect,
	output logic [4:0] lowDriveLevelSelect
);
	import level_sel_pkg::*;

	// ==========================================================
	// Address decode
	// Bit 0 ignored: both registers are whole 16-bit words
	function automatic regHit_type regHit(input regAddr_type a);
		regHit_type h;
		h = HIT_NONE;
		if ({a[11:1], 1'b0} == `LVL_CTRL_OFFSET) begin
			h = HIT_CTRL;
		end else if ({a[11:1], 1'b0} == `LVL_REV_OFFSET) begin
			h = HIT_REV;
		end
		return h;
	endfunction

	// ==========================================================
	// Reset release
	// Assert is immediate, release waits two edges so that every
	// flop leaves reset in the same cycle.
	logic rstSync1_r, rstSync1_nxt;
	logic rstSync2_r, rstSync2_nxt;
	logic rstnInt;

	always_comb begin
		rstSync1_nxt = 1'b1;
		rstSync2_nxt = rstSync1_r;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end else begin
			rstSync1_r <= rstSync1_nxt;
			rstSync2_r <= rstSync2_nxt;
		end
	end

	assign rstnInt = rstSync2_r;

	// ==========================================================
	// Bus pin synchroniser
	// Every bus pin is asynchronous, so each bit passes three flops
	// and a new level counts once stages two and three agree.
	// The strobe travels in the same word, so address and data seen
	// with it settle at the same edge: costs latency, but asks no
	// setup margin of the master.
	localparam int PIN_W = $bits(regAddr_type) + $bits(laneEn_type)
		+ $bits(regWord_type) + 2;

	logic [PIN_W-1:0] pinRaw;
	wire [PIN_W-1:0] pinAgree;
	logic [PIN_W-1:0] pinSync1_r, pinSync1_nxt;
	logic [PIN_W-1:0] pinSync2_r, pinSync2_nxt;
	logic [PIN_W-1:0] pinSync3_r, pinSync3_nxt;
	logic [PIN_W-1:0] pinSeen_r, pinSeen_nxt;
	logic strobeSeen;
	logic wrSeenN;
	laneEn_type laneSeenN;
	regAddr_type addrSeen;
	regWord_type wdataSeen;

	// Strobe inverted so that a cleared filter means idle
	assign pinRaw = {~busStrobeN, busWriteN, busLaneN, busAddr,
		busWdata};

	genvar b;
	generate
		for (b = 0; b < PIN_W; b++) begin : pinBit
			assign pinAgree[b] = pinSync2_r[b] == pinSync3_r[b];
		end
	endgenerate

	always_comb begin
		pinSync1_nxt = pinRaw;
		pinSync2_nxt = pinSync1_r;
		pinSync3_nxt = pinSync2_r;
		pinSeen_nxt = (pinSeen_r & ~pinAgree) | (pinSync3_r & pinAgree);
	end

	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			pinSync1_r <= '0;
			pinSync2_r <= '0;
			pinSync3_r <= '0;
			pinSeen_r <= '0;
		end else begin
			pinSync1_r <= pinSync1_nxt;
			pinSync2_r <= pinSync2_nxt;
			pinSync3_r <= pinSync3_nxt;
			pinSeen_r <= pinSeen_nxt;
		end
	end

	assign {strobeSeen, wrSeenN, laneSeenN, addrSeen,
		wdataSeen} = pinSeen_r;

	// ==========================================================
	// Register bank and bus answer
	busState_type state_r, state_nxt;
	regWord_type ctrl_r, ctrl_nxt;
	regWord_type rdata_r, rdata_nxt;
	regWord_type revWord;
	logic ack_r, ack_nxt;
	logic err_r, err_nxt;
	regHit_type hit;

	assign revWord = {`LVL_REV_UPPER, HW_REVISION};
	assign hit = regHit(addrSeen);

	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		rdata_nxt = rdata_r;
		ack_nxt = ack_r;
		err_nxt = err_r;
		case (state_r)
			ST_IDLE: begin
				if (strobeSeen) begin
					state_nxt = ST_ANSWER;
					rdata_nxt = `LVL_WORD_ZERO;
					if (hit == HIT_CTRL) begin
						ack_nxt = 1'b1;
						// Every bit is stored, spare ones included
						if (!wrSeenN) begin
							if (!laneSeenN[`LVL_LANE_HI]) begin
								ctrl_nxt[15:8] = wdataSeen[15:8];
							end
							if (!laneSeenN[`LVL_LANE_LO]) begin
								ctrl_nxt[7:0] = wdataSeen[7:0];
							end
						end else begin
							rdata_nxt = ctrl_r;
						end
					end else if (hit == HIT_REV) begin
						// Writes to the revision word are taken and dropped
						ack_nxt = 1'b1;
						if (wrSeenN) begin
							rdata_nxt = revWord;
						end
					end else begin
						err_nxt = 1'b1;
					end
				end
			end
			ST_ANSWER: begin
				// Answer holds until the master lets go of the strobe
				if (!strobeSeen) begin
					state_nxt = ST_IDLE;
					ack_nxt = 1'b0;
					err_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			state_r <= ST_IDLE;
			ctrl_r <= `LVL_CTRL_RESET;
			rdata_r <= `LVL_WORD_ZERO;
			ack_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
			err_r <= err_nxt;
		end
	end

	assign busRdata = rdata_r;
	assign busAckN = ~ack_r;
	assign busErrN = ~err_r;

	// ==========================================================
	// Group decode
	// Spare bits never reach the decoder's outputs
	level_sel_if lvl ();

	assign lvl.ctrlWord = ctrl_r;

	level_group_decode #(
		.GROUPS(`LVL_GROUPS)
	) decode (
		.clk(clk),
		.rstnInt(rstnInt),
		.lvl(lvl.decoder)
	);

	assign highDriveLevelSelect = lvl.highSel;
	assign lowDriveLevelSelect = lvl.lowSel;
endmodule
`default_nettype wire

// ### verification/level_sel_sva.sv
`timescale 1ns/1ps
`default_nettype none
module level_sel_sva
	import level_sel_pkg::*;
#(parameter logic [7:0] HW_REVISION = 8'h01) (
	input wire logic clk, rstn, busWriteN, busAckN,
	input wire regAddr_type busAddr,
	input wire laneEn_type busLaneN,
	input wire regWord_type busWdata,
	input wire logic [15:0] busRdata,
	input wire logic [4:0] highDriveLevelSelect, lowDriveLevelSelect
);
	logic ackQ;
	regWord_type shadow;
	wire logic take, wrTake, ctlHit, revHit;
	// ==========================================================
	// Accepted access, seen on the falling ack
	always_ff @(posedge clk) ackQ <= busAckN;
	assign take = ackQ & ~busAckN;
	assign ctlHit = busAddr[11:1] == 11'h500;
	assign revHit = busAddr[11:1] == 11'h501;
	assign wrTake = take & ~busWriteN & ctlHit;
	// Expected control word, rebuilt from the accepted writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shadow <= 16'h0000;
		end else if (wrTake) begin
			shadow <= {busLaneN[1] ? shadow[15:8] : busWdata[15:8],
				busLaneN[0] ? shadow[7:0] : busWdata[7:0]};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	reset_zero_a: assert property ($rose(rstn) |->
		{highDriveLevelSelect, lowDriveLevelSelect} == 10'h000)
		else $error("selects not zero after reset");
	high_sel_a: assert property (wrTake && !busLaneN[1] |=>
		highDriveLevelSelect == $past(busWdata[12:8]))
		else $error("high select wrong");
	low_sel_a: assert property (wrTake && !busLaneN[0] |=>
		lowDriveLevelSelect == $past(busWdata[4:0]))
		else $error("low select wrong");
	sel_hold_a: assert property (!$stable({highDriveLevelSelect,
		lowDriveLevelSelect}) |-> $past(wrTake))
		else $error("select moved without write");
	ctrl_read_a: assert property (take && busWriteN && ctlHit |->
		busRdata[12:8] == highDriveLevelSelect &&
		busRdata[4:0] == lowDriveLevelSelect)
		else $error("control readback wrong");
	rev_upper_a: assert property (take && busWriteN && revHit |->
		busRdata[15:8] == 8'h00) else $error("revision upper wrong");
	rev_code_a: assert property (take && busWriteN && revHit |->
		busRdata[7:0] == HW_REVISION) else $error("revision code wrong");
	spare_read_a: assert property (take && busWriteN && ctlHit |->
		busRdata == shadow) else $error("control word readback wrong");
endmodule
bind output_level_select_regs level_sel_sva #(.HW_REVISION(HW_REVISION))
	sva_u (.clk, .rstn, .busWriteN, .busAckN, .busAddr, .busLaneN,
	.busWdata, .busRdata, .highDriveLevelSelect, .lowDriveLevelSelect);
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import level_sel_pkg::*;
	localparam logic [7:0] REV = 8'h5a;
	logic clk = 0, rstn = 0, busStrobeN = 1, busWriteN = 1;
	regAddr_type busAddr = 12'h000;
	laneEn_type busLaneN = 2'h3, l;
	regWord_type busWdata = 16'h0000, q, d, ctrl;
	logic [15:0] busRdata;
	logic busAckN, busErrN;
	logic [1:0] ans;
	logic [4:0] highDriveLevelSelect, lowDriveLevelSelect;
	logic [31:0] rnd = 32'h0ffed6b8;
	int errors = 0, checksDone = 0;
	output_level_select_regs #(.HW_REVISION(REV)) dut_u (.clk, .rstn,
		.busAddr, .busStrobeN, .busWriteN, .busLaneN, .busWdata,
		.busRdata, .busAckN, .busErrN, .highDriveLevelSelect,
		.lowDriveLevelSelect);
	initial forever #25 clk = ~clk;
	// ==========================================================
	// Helpers
	function logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function regWord_type merge(regWord_type o, n, laneEn_type m);
		return {m[1] ? o[15:8] : n[15:8], m[0] ? o[7:0] : n[7:0]};
	endfunction
	// Expected answer {err, ack}: bit 0 ignored, two words mapped
	function logic [1:0] answer(regAddr_type a);
		if (a[11:1] == 11'h500 || a[11:1] == 11'h501)
			return 2'h1;
		return 2'h2;
	endfunction
	task tick();
		@(posedge clk);
		#1;
	endtask
	task chk(string nm, regWord_type e, g);
		checksDone++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task stop_test();
		if (errors == 0 && checksDone > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Strobe held until ack or err, then released until both clear
	task acc(logic wr, regAddr_type a, laneEn_type m, regWord_type v);
		int n;
		n = 0;
		busAddr = a;
		busWriteN = !wr;
		busLaneN = m;
		busWdata = v;
		busStrobeN = 0;
		while ((busAckN & busErrN) !== 1'b0 && n < 20) begin
			tick();
			n++;
		end
		q = busRdata;
		ans = {!busErrN, !busAckN};
		busStrobeN = 1;
		while ((busAckN & busErrN) !== 1'b1 && n < 40) begin
			tick();
			n++;
		end
		chk("ack", 16'h0, 16'(n >= 20));
		chk("answer", 16'(answer(a)), 16'(ans));
		tick();
	endtask
	task post_reset();
		rstn = 0;
		repeat (16) tick();
		rstn = 1;
		repeat (3) tick();
		chk("hsel", 16'h0, 16'(highDriveLevelSelect));
		chk("lsel", 16'h0, 16'(lowDriveLevelSelect));
		acc(0, 12'ha00, 2'h3, 16'h0);
		chk("ctrl", 16'h0, q);
		ctrl = 16'h0;
	endtask
	initial begin
		#300us;
		errors++;
		stop_test();
	end
	initial begin
		post_reset();
		for (int i = 0; i < 14; i++) begin
			rnd = lfsr(rnd);
			d = i == 0 ? 16'he0e0 : i == 1 ? 16'h1f1f : rnd[15:0];
			l = i < 2 ? 2'h0 : rnd[17:16];
			acc(1, 12'ha00, l, d);
			ctrl = merge(ctrl, d, l);
			acc(0, 12'ha00, 2'h3, 16'h0);
			chk("ctrl", ctrl, q);
			chk("hsel", 16'(ctrl[12:8]), 16'(highDriveLevelSelect));
			chk("lsel", 16'(ctrl[4:0]), 16'(lowDriveLevelSelect));
		end
		acc(1, 12'ha02, 2'h0, 16'hffff);
		acc(1, 12'ha04, 2'h0, 16'hffff);
		acc(0, 12'ha06, 2'h3, 16'h0);
		chk("errdata", 16'h0, q);
		acc(0, 12'ha01, 2'h3, 16'h0);
		chk("ctrl", ctrl, q);
		chk("hsel", 16'(ctrl[12:8]), 16'(highDriveLevelSelect));
		chk("lsel", 16'(ctrl[4:0]), 16'(lowDriveLevelSelect));
		acc(0, 12'ha02, 2'h3, 16'h0);
		chk("rev", {8'h00, REV}, q);
		chk("revhi", 16'h0, 16'(q[15:8]));
		post_reset();
		stop_test();
	end
endmodule
`default_nettype wire
